// ==== verilog/dfm_fault_manager.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Display only the highest-priority active fault.
// - Priority order flash down to travel limit.
// - Button or reset input clears resettable faults.
// - Encoder and self-test faults need power cycle.
// - Travel limit faults clear themselves automatically.
// - Travel limit fault keeps bridge enabled.
// - Checksum failure latches; only reprogramming clears.
// - Missed 10 ms kick resets, forces I/O off.
// - Self-test failure ignores every reset action.
// - Check nonvolatile memory at every power-up.
// - Module fault shows digit three.
// - Module presence mismatch at power-up faults.
// - Configuration clears by download or 10 s hold.
// - Power stage heat, current, supply loss fault.
// - Enable toggling above 10 Hz faults.
// - Bus above 440 V faults.
// - Bus below 96 V for 50 ms faults.
// - Equal complementary encoder lines fault.
// - Open motor thermal switch faults.
// - Speed above overspeed limit faults.
// - Following error limit, default 0.2 rev.
// - All segments lit under one second, bridge off.
module dfm_fault_manager
	import dfm_pkg::*;
#(
	parameter int WDOG_CYC   = WDOG_CYC_DEF,
	parameter int LOWBUS_CYC = LOWBUS_CYC_DEF,
	parameter int CFG_CYC    = CFG_CYC_DEF,
	parameter int LAMP_CYC   = LAMP_CYC_DEF,
	parameter int ENA_CYC    = ENA_CYC_DEF
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              flashSumBad,
	input  wire logic              flashReprogDone,
	input  wire logic              wdogKick,
	input  wire logic              selfTestFail,
	input  wire logic              nvmCheckDone,
	input  wire logic              nvmBad,
	input  wire logic              modPresent,
	input  wire logic              modPresentPrev,
	input  wire logic              cfgDownloadOk,
	input  wire logic              stageOverTemp,
	input  wire logic              stageOverCurrent,
	input  wire logic              stageLogicLoss,
	input  wire logic              driveEnable,
	input  wire logic [9:0]        busVolts,
	input  wire logic [2:0]        encTrue,
	input  wire logic [2:0]        encComp,
	input  wire logic              encStateBad,
	input  wire logic              motorThermalOpen,
	input  wire logic              shuntOverload,
	input  wire logic [15:0]       motorSpeed,
	input  wire logic [15:0]       overspeedLimit,
	input  wire logic [15:0]       followError,
	input  wire logic              followLimitWrite,
	input  wire logic [15:0]       followLimitIn,
	input  wire logic              travelPos,
	input  wire logic              travelNeg,
	input  wire logic              resetButton,
	input  wire logic              resetInput,
	input  wire logic              moduleFault,
	output logic [NFAULT-1:0]      faultVec_reg,
	output dfm_code_t              faultCode_reg,
	output logic                   bridgeOff_reg,
	output logic                   segAllOn_reg,
	output logic                   showDigit3_reg,
	output logic                   hwReset_reg,
	output logic                   ioOff_reg,
	output logic [15:0]            followLimit_reg
);

	dfm_tmr_if tmr [NTMR] ();
	localparam int LIM [NTMR] = '{WDOG_CYC, LOWBUS_CYC, CFG_CYC, LAMP_CYC, ENA_CYC};

	for (genvar g = 0; g < NTMR; g++) begin : g_tmr
		dfm_timer #(.LIMIT(LIM[g])) u_tmr (
			.mclk    (mclk),
			.sys_rst (sys_rst),
			.tif     (tmr[g])
		);
	end

	function automatic dfm_code_t topCode(input logic [NFAULT-1:0] v);
		topCode = CODE_NONE;
		for (int i = NFAULT - 1; i >= 0; i--) begin
			if (v[i]) begin
				topCode = dfm_code_t'(4'(i + 1));
			end
		end
	endfunction

	logic              wdogDone_reg;
	logic              cfgDone_reg;
	logic              enable_reg;
	logic              enaSeen_reg;
	logic              startup_reg;
	logic              nvmChecked_reg;
	logic              wdogDone_next;
	logic              cfgDone_next;
	logic              enable_next;
	logic              enaSeen_next;
	logic              startup_next;
	logic              nvmChecked_next;
	logic [NFAULT-1:0] faultVec_next;
	logic [NFAULT-1:0] setVec;
	logic [NFAULT-1:0] clrVec;
	dfm_code_t         faultCode_next;
	logic              bridgeOff_next;
	logic              segAllOn_next;
	logic              showDigit3_next;
	logic              hwReset_next;
	logic              ioOff_next;
	logic [15:0]       followLimit_next;
	logic              resetReq;
	logic              enaRise;
	logic              wdogBite;
	logic              cfgHoldHit;

	// The watchdog counts only between kicks; the hold timer runs while the button is held.
	assign tmr[T_WDOG].run = !wdogKick;
	assign tmr[T_LOWB].run = busVolts < BUS_LOW_V;
	assign tmr[T_CFGH].run = resetButton;
	assign tmr[T_LAMP].run = 1'b1;
	assign tmr[T_ENA].run  = !enaRise;

	always_comb begin
		resetReq   = resetButton || resetInput;
		enaRise    = driveEnable && !enable_reg;
		wdogBite   = tmr[T_WDOG].done && !wdogDone_reg;
		cfgHoldHit = tmr[T_CFGH].done && !cfgDone_reg;

		setVec = VEC_ZERO;
		setVec[F_FLASH]  = flashSumBad;
		setVec[F_WDOG]   = wdogBite;
		setVec[F_POST]   = selfTestFail;
		setVec[F_NVM]    = nvmCheckDone && !nvmChecked_reg && nvmBad;
		setVec[F_CFG]    = startup_reg && (modPresentPrev != modPresent);
		// A second enable edge before the period timer expires means toggling too fast.
		setVec[F_PWRMOD] = stageOverTemp || stageOverCurrent || stageLogicLoss
			|| (enaRise && enaSeen_reg && !tmr[T_ENA].done);
		setVec[F_BUSHI]  = busVolts > BUS_HIGH_V;
		setVec[F_BUSLO]  = tmr[T_LOWB].done;
		setVec[F_ENCST]  = encStateBad;
		setVec[F_ENCLN]  = |(~(encTrue ^ encComp));
		setVec[F_MOTTH]  = motorThermalOpen;
		setVec[F_SHUNT]  = shuntOverload;
		setVec[F_OVSPD]  = motorSpeed > overspeedLimit;
		setVec[F_FERR]   = followError > followLimit_reg;

		// Power-cycle faults have no clear term at all; only sys_rst removes them.
		clrVec = resetReq ? RESETTABLE_MASK : VEC_ZERO;
		clrVec[F_FLASH] = flashReprogDone;
		clrVec[F_CFG]   = cfgDownloadOk || cfgHoldHit;

		// Set wins over clear so an event in the clearing cycle is not lost.
		faultVec_next = setVec | (faultVec_reg & ~clrVec);
		faultVec_next[F_TRAVEL] = travelPos || travelNeg;

		faultCode_next  = topCode(faultVec_next);
		segAllOn_next   = !tmr[T_LAMP].done;
		bridgeOff_next  = (|(faultVec_next & BRIDGE_MASK)) || segAllOn_next;
		showDigit3_next = moduleFault;
		hwReset_next    = wdogBite;
		ioOff_next      = faultVec_next[F_WDOG];

		followLimit_next = followLimitWrite ? followLimitIn : followLimit_reg;
		wdogDone_next    = tmr[T_WDOG].done;
		cfgDone_next     = tmr[T_CFGH].done;
		enable_next      = driveEnable;
		enaSeen_next     = enaSeen_reg || enaRise;
		startup_next     = 1'b0;
		nvmChecked_next  = nvmChecked_reg || nvmCheckDone;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			faultVec_reg    <= VEC_ZERO;
			faultCode_reg   <= CODE_NONE;
			bridgeOff_reg   <= 1'b1;
			segAllOn_reg    <= 1'b1;
			showDigit3_reg  <= 1'b0;
			hwReset_reg     <= 1'b0;
			ioOff_reg       <= 1'b0;
			followLimit_reg <= FERR_LIMIT_DEF;
			wdogDone_reg    <= 1'b0;
			cfgDone_reg     <= 1'b0;
			enable_reg      <= 1'b0;
			enaSeen_reg     <= 1'b0;
			startup_reg     <= 1'b1;
			nvmChecked_reg  <= 1'b0;
		end else begin
			faultVec_reg    <= faultVec_next;
			faultCode_reg   <= faultCode_next;
			bridgeOff_reg   <= bridgeOff_next;
			segAllOn_reg    <= segAllOn_next;
			showDigit3_reg  <= showDigit3_next;
			hwReset_reg     <= hwReset_next;
			ioOff_reg       <= ioOff_next;
			followLimit_reg <= followLimit_next;
			wdogDone_reg    <= wdogDone_next;
			cfgDone_reg     <= cfgDone_next;
			enable_reg      <= enable_next;
			enaSeen_reg     <= enaSeen_next;
			startup_reg     <= startup_next;
			nvmChecked_reg  <= nvmChecked_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence sBite;
		$rose(tmr[T_WDOG].done);
	endsequence

	chk_code_priority: assert property (faultVec_reg[F_FLASH] |-> faultCode_reg == CODE_FLASH)
		else $error("flash fault not shown as top code");
	chk_code_order: assert property (
		(faultVec_reg[F_FERR] && faultVec_reg[F_TRAVEL] && faultVec_reg[F_FERR-1:0] == 13'h0)
		|-> faultCode_reg == CODE_FERR)
		else $error("following error not above travel limit");
	chk_reset_clears: assert property (
		(resetReq && !motorThermalOpen) |=> !faultVec_reg[F_MOTTH])
		else $error("motor thermal fault survived reset");
	chk_power_sticky: assert property (faultVec_reg[F_ENCLN] |=> faultVec_reg[F_ENCLN])
		else $error("encoder line fault dropped without power cycle");
	chk_test_sticky: assert property (faultVec_reg[F_POST] |=> faultVec_reg[F_POST])
		else $error("self-test fault dropped without power cycle");
	chk_travel_auto: assert property (!(travelPos || travelNeg) |=> !faultVec_reg[F_TRAVEL])
		else $error("travel fault not cleared automatically");
	chk_travel_bridge: assert property (
		(faultVec_reg[F_TRAVEL-1:0] == 14'h0 && !segAllOn_reg) |-> !bridgeOff_reg)
		else $error("travel fault alone disabled the bridge");
	chk_wdog_bite: assert property (sBite |=> hwReset_reg && ioOff_reg && faultVec_reg[F_WDOG])
		else $error("watchdog timeout without reset and fault");
	chk_bus_high: assert property ((busVolts > BUS_HIGH_V) |=> faultVec_reg[F_BUSHI])
		else $error("high bus fault not raised");
	chk_enc_pair: assert property ((encTrue[0] == encComp[0]) |=> faultVec_reg[F_ENCLN])
		else $error("equal encoder pair not flagged");
	chk_digit_three: assert property (moduleFault |=> showDigit3_reg)
		else $error("module fault not shown as digit three");
	chk_lamp_bridge: assert property (segAllOn_reg |-> bridgeOff_reg)
		else $error("bridge enabled during lamp test");

endmodule // dfm_fault_manager

// ==== include/dfm_pkg.sv ====
package dfm_pkg;

	localparam int CLK_HZ = 100_000_000;

	// Times in engineering units, and the cycle counts derived from them.
	localparam int WDOG_MS       = 10;
	localparam int LOWBUS_MS     = 50;
	localparam int CFG_HOLD_S    = 10;
	localparam int LAMP_MS       = 900;
	localparam int ENA_MAX_HZ    = 10;
	localparam int WDOG_CYC_DEF   = WDOG_MS * (CLK_HZ / 1000);
	localparam int LOWBUS_CYC_DEF = LOWBUS_MS * (CLK_HZ / 1000);
	localparam int CFG_CYC_DEF    = CFG_HOLD_S * CLK_HZ;
	localparam int LAMP_CYC_DEF   = LAMP_MS * (CLK_HZ / 1000);
	localparam int ENA_CYC_DEF    = CLK_HZ / ENA_MAX_HZ;

	localparam logic [9:0] BUS_HIGH_V = 10'h1b8;
	localparam logic [9:0] BUS_LOW_V  = 10'h060;

	// Following error limit default: 0.2 rev at 8192 counts per rev.
	localparam logic [15:0] FERR_LIMIT_DEF = 16'h0666;

	localparam int NFAULT = 15;

	// Latch bit positions, highest priority at bit 0.
	localparam int F_FLASH  = 0;
	localparam int F_WDOG   = 1;
	localparam int F_POST   = 2;
	localparam int F_NVM    = 3;
	localparam int F_CFG    = 4;
	localparam int F_PWRMOD = 5;
	localparam int F_BUSHI  = 6;
	localparam int F_BUSLO  = 7;
	localparam int F_ENCST  = 8;
	localparam int F_ENCLN  = 9;
	localparam int F_MOTTH  = 10;
	localparam int F_SHUNT  = 11;
	localparam int F_OVSPD  = 12;
	localparam int F_FERR   = 13;
	localparam int F_TRAVEL = 14;

	localparam logic [NFAULT-1:0] RESETTABLE_MASK = 15'h3cea;
	localparam logic [NFAULT-1:0] BRIDGE_MASK     = 15'h3fff;
	localparam logic [NFAULT-1:0] VEC_ZERO        = 15'h0000;

	typedef enum logic [3:0] {
		CODE_NONE   = 4'h0,
		CODE_FLASH  = 4'h1,
		CODE_WDOG   = 4'h2,
		CODE_POST   = 4'h3,
		CODE_NVM    = 4'h4,
		CODE_CFG    = 4'h5,
		CODE_PWRMOD = 4'h6,
		CODE_BUSHI  = 4'h7,
		CODE_BUSLO  = 4'h8,
		CODE_ENCST  = 4'h9,
		CODE_ENCLN  = 4'ha,
		CODE_MOTTH  = 4'hb,
		CODE_SHUNT  = 4'hc,
		CODE_OVSPD  = 4'hd,
		CODE_FERR   = 4'he,
		CODE_TRAVEL = 4'hf
	} dfm_code_t;

	localparam int NTMR = 5;
	localparam int T_WDOG = 0;
	localparam int T_LOWB = 1;
	localparam int T_CFGH = 2;
	localparam int T_LAMP = 3;
	localparam int T_ENA  = 4;

endpackage

// ==== include/dfm_tmr_if.sv ====
`timescale 1ns/1ps
interface dfm_tmr_if;
	logic run;
	logic done;
	modport owner (output run, input done);
	modport timer (input run, output done);
endinterface

// ==== verilog/dfm_timer.sv ====
`timescale 1ns/1ps
// Counts cycles while run is high; done is high once LIMIT cycles have passed, until run falls.
module dfm_timer #(
	parameter int LIMIT = 1
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	dfm_tmr_if.timer  tif
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic        done_reg;
	logic        done_next;

	always_comb begin
		count_next = count_reg;
		if (!tif.run) begin
			count_next = 32'h0;
		end else if (count_reg < 32'(LIMIT)) begin
			count_next = count_reg + 32'h1;
		end
		done_next = tif.run && (count_next >= 32'(LIMIT));
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 32'h0;
			done_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end

	assign tif.done = done_reg;
endmodule // dfm_timer

// ==== verif/dfm_partner.sv ====
`timescale 1ns/1ps
// Stands in for the firmware and the encoder; kicks well inside the watchdog period.
module dfm_partner (
	input  wire logic       mclk,
	input  wire logic       kickOn,
	input  wire logic       encBreak,
	output logic            wdogKick,
	output logic [2:0]      encTrue,
	output logic [2:0]      encComp
);
	logic [2:0] phase;
	initial begin
		phase = 3'h0;
		wdogKick = 1'b0;
		encTrue = 3'h5;
		encComp = 3'h2;
	end
	// The line pattern moves every cycle so that a stuck pair cannot hide.
	always @(negedge mclk) begin
		phase <= phase + 3'h1;
		wdogKick <= kickOn && (phase == 3'h0);
		encTrue <= {phase[2], phase[1] ^ phase[2], phase[0]};
		encComp <= ~{phase[2], phase[1] ^ phase[2], phase[0]} ^ {2'h0, encBreak};
	end
endmodule // dfm_partner

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	import dfm_pkg::*;
	logic mclk, sys_rst, flashSumBad, flashReprogDone, wdogKick, selfTestFail, nvmCheckDone;
	logic nvmBad, modPresent, modPresentPrev, cfgDownloadOk, stageOverTemp, stageOverCurrent;
	logic stageLogicLoss, driveEnable, encStateBad, motorThermalOpen, shuntOverload;
	logic followLimitWrite, travelPos, travelNeg, resetButton, resetInput, moduleFault;
	logic kickOn, encBreak, bridgeOff_reg, segAllOn_reg, showDigit3_reg, hwReset_reg, ioOff_reg;
	logic [9:0]        busVolts;
	logic [2:0]        encTrue, encComp;
	logic [15:0]       motorSpeed, overspeedLimit, followError, followLimitIn, followLimit_reg;
	logic [NFAULT-1:0] faultVec_reg;
	dfm_code_t         faultCode_reg;
	int                mismatches, cmpCount;

	dfm_fault_manager #(.WDOG_CYC(20), .LOWBUS_CYC(10), .CFG_CYC(30), .LAMP_CYC(8),
		.ENA_CYC(16)) i_dut (
		.mclk(mclk), .sys_rst(sys_rst), .flashSumBad(flashSumBad),
		.flashReprogDone(flashReprogDone), .wdogKick(wdogKick), .selfTestFail(selfTestFail),
		.nvmCheckDone(nvmCheckDone), .nvmBad(nvmBad), .modPresent(modPresent),
		.modPresentPrev(modPresentPrev), .cfgDownloadOk(cfgDownloadOk),
		.stageOverTemp(stageOverTemp), .stageOverCurrent(stageOverCurrent),
		.stageLogicLoss(stageLogicLoss), .driveEnable(driveEnable), .busVolts(busVolts),
		.encTrue(encTrue), .encComp(encComp), .encStateBad(encStateBad),
		.motorThermalOpen(motorThermalOpen), .shuntOverload(shuntOverload),
		.motorSpeed(motorSpeed), .overspeedLimit(overspeedLimit), .followError(followError),
		.followLimitWrite(followLimitWrite), .followLimitIn(followLimitIn),
		.travelPos(travelPos), .travelNeg(travelNeg), .resetButton(resetButton),
		.resetInput(resetInput), .moduleFault(moduleFault), .faultVec_reg(faultVec_reg),
		.faultCode_reg(faultCode_reg), .bridgeOff_reg(bridgeOff_reg),
		.segAllOn_reg(segAllOn_reg), .showDigit3_reg(showDigit3_reg),
		.hwReset_reg(hwReset_reg), .ioOff_reg(ioOff_reg), .followLimit_reg(followLimit_reg)
	);
	dfm_partner i_partner (.mclk(mclk), .kickOn(kickOn), .encBreak(encBreak),
		.wdogKick(wdogKick), .encTrue(encTrue), .encComp(encComp));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmpCount++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Bounded wait; running out of cycles shows up as a failed comparison.
	task automatic wait_code(input logic [3:0] exp);
		int n;
		n = 0;
		while (n < 40 && faultCode_reg !== exp) begin
			tick(1);
			n++;
		end
		chk(faultCode_reg, exp, "fault code");
	endtask

	task automatic press(input bit useInput);
		if (useInput) resetInput = 1'b1; else resetButton = 1'b1;
		tick(1);
		resetInput = 1'b0;
		resetButton = 1'b0;
		tick(2);
	endtask

	task automatic do_reset(input logic mism, input logic nbad);
		sys_rst = 1'b1;
		modPresentPrev = ~mism;
		nvmBad = nbad;
		tick(3);
		chk(bridgeOff_reg, 1'b1, "bridge in reset");
		chk(followLimit_reg, 16'h0666, "follow limit");
		tick(3);
		sys_rst = 1'b0;
		tick(1);
		chk(segAllOn_reg, 1'b1, "lamp test on");
		tick(12);
		chk(segAllOn_reg, 1'b0, "lamp test off");
	endtask

	task automatic cause(input int idx, input logic v);
		case (idx)
			0: flashSumBad = v;
			1: kickOn = ~v;
			2: selfTestFail = v;
			5: stageOverTemp = v;
			6: busVolts = v ? 10'h1b9 : 10'h12c;
			7: busVolts = v ? 10'h05f : 10'h12c;
			8: encStateBad = v;
			9: encBreak = v;
			10: motorThermalOpen = v;
			11: shuntOverload = v;
			12: motorSpeed = v ? 16'h0101 : 16'h0100;
			13: followError = v ? 16'h0667 : 16'h0666;
			default: travelPos = v;
		endcase
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		{flashSumBad, flashReprogDone, selfTestFail, cfgDownloadOk, stageOverTemp} = 5'h00;
		{stageOverCurrent, stageLogicLoss, driveEnable, encStateBad, motorThermalOpen} = 5'h00;
		{shuntOverload, followLimitWrite, travelPos, travelNeg, resetButton} = 5'h00;
		{resetInput, moduleFault, encBreak, nvmBad} = 4'h0;
		{kickOn, nvmCheckDone, modPresent, modPresentPrev} = 4'hf;
		busVolts = 10'h12c;
		motorSpeed = 16'h0100;
		overspeedLimit = 16'h0100;
		followError = 16'h0666;
		followLimitIn = 16'h0010;
		sys_rst = 1'b1;
		do_reset(1'b0, 1'b0);
		chk(faultVec_reg, 15'h0000, "clean start");
		// Each step adds a fault above all those already active.
		for (int i = 14; i >= 0; i--) begin
			if (i != 3 && i != 4) begin
				cause(i, 1'b1);
				wait_code(4'(i + 1));
				chk(bridgeOff_reg, i != 14, "bridge");
			end
			if (i == 1) chk(ioOff_reg, 1'b1, "io off");
			if (i == 1) chk(hwReset_reg, 1'b1, "hw reset pulse");
		end
		for (int i = 0; i < 15; i++) cause(i, 1'b0);
		tick(3);
		chk(faultVec_reg, 15'h3fe7, "latched after causes gone");
		chk(hwReset_reg, 1'b0, "hw reset pulse over");
		press(1'b0);
		chk(faultVec_reg, 15'h0305, "after button");
		chk(ioOff_reg, 1'b0, "io released");
		press(1'b1);
		chk(faultVec_reg, 15'h0305, "after reset input");
		flashReprogDone = 1'b1;
		tick(1);
		flashReprogDone = 1'b0;
		tick(2);
		chk(faultVec_reg, 15'h0304, "after reprogram");
		$display("test priority and clearing done");
		do_reset(1'b0, 1'b0);
		for (int j = 0; j < 3; j++) begin
			{stageLogicLoss, stageOverCurrent, stageOverTemp} = 3'(1 << j);
			tick(3);
			chk(faultVec_reg, 15'h0020, "power stage");
			{stageLogicLoss, stageOverCurrent, stageOverTemp} = 3'h0;
			press(1'b1);
		end
		busVolts = 10'h1b8;
		tick(3);
		chk(faultVec_reg, 15'h0000, "bus at limit");
		busVolts = 10'h05f;
		tick(6);
		chk(faultVec_reg, 15'h0000, "low bus inside debounce");
		tick(6);
		chk(faultVec_reg, 15'h0080, "low bus after debounce");
		// The debounce timer must fall before the press, or its set would win.
		busVolts = 10'h12c;
		tick(1);
		press(1'b0);
		driveEnable = 1'b1;
		tick(2);
		driveEnable = 1'b0;
		tick(2);
		driveEnable = 1'b1;
		tick(3);
		chk(faultVec_reg, 15'h0020, "fast enable toggle");
		press(1'b0);
		driveEnable = 1'b0;
		tick(20);
		driveEnable = 1'b1;
		tick(3);
		chk(faultVec_reg, 15'h0000, "slow enable toggle");
		travelNeg = 1'b1;
		tick(3);
		chk(bridgeOff_reg, 1'b0, "travel keeps bridge");
		chk(faultCode_reg, 4'hf, "travel code");
		travelNeg = 1'b0;
		tick(3);
		chk(faultVec_reg, 15'h0000, "travel auto clear");
		moduleFault = 1'b1;
		tick(2);
		chk(showDigit3_reg, 1'b1, "digit three");
		moduleFault = 1'b0;
		tick(2);
		chk(showDigit3_reg, 1'b0, "digit three gone");
		followLimitWrite = 1'b1;
		tick(1);
		followLimitWrite = 1'b0;
		tick(1);
		chk(followLimit_reg, 16'h0010, "limit write");
		$display("test detection done");
		do_reset(1'b1, 1'b1);
		chk(faultVec_reg, 15'h0018, "memory and config");
		chk(faultCode_reg, 4'h4, "memory first");
		cfgDownloadOk = 1'b1;
		tick(1);
		cfgDownloadOk = 1'b0;
		tick(2);
		chk(faultVec_reg, 15'h0008, "download clears");
		press(1'b0);
		chk(bridgeOff_reg, 1'b0, "all clear");
		modPresent = 1'b0;
		do_reset(1'b0, 1'b0);
		chk(faultVec_reg, 15'h0010, "module removed");
		resetButton = 1'b1;
		tick(25);
		resetButton = 1'b0;
		tick(3);
		chk(faultVec_reg, 15'h0010, "short hold");
		resetButton = 1'b1;
		tick(36);
		chk(faultVec_reg, 15'h0000, "long hold");
		resetButton = 1'b0;
		$display("test power-up faults done");
		report_and_stop();
	end
endmodule // tb
